/* phc_device.sv */
// Purpose: supply controller end: static handover and serial access
// Assumes: host keeps a byte gap; reg_rdata_i valid one cycle after read
// Notes: serial shifting runs on the host clock, never oversampled
// Notes on behaviour
// - Start-up drives enables, host pins ignored
// - Static mode: ready pin input, weak pull-up
// - Start-up done: capture ready, then power good
// - Ready change: drop pull-up, hand to pins
// - Pins one to four enable four supplies
// - Ready high: fourth supply off, pins held valid
// - Host sets pins, then pulls ready low
// - Dynamic: select pull-up off until button event
// - Select high means serial, low two-wire
// - Pull-up off again after the choice
// - Choose once per start-up, hold it
// - Wait about one microsecond before sampling
// - Pin roles fixed per chosen interface
// - Access is command byte then data byte
// - Command top bit read, seven address bits
// - Read data driven out, top bit first
// - Release output after last bit or deselect
// - Writes shift in top first, output idle
// - Change on falling, capture on rising edge
// - Host clocks only inside framed transfers
// - Shared data line needs host tri-state
// - Gap between bytes, no clock oversampling
`timescale 1ns/1ps
`include "phc_regs.svh"
module phc_device #(
    parameter int CHARGE_CYC = `PHC_CHARGE_CYC
) (
    phc_link_if.dev lnk,
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic static_mode_i,
    input wire logic seq_start_i,
    input wire logic startup_done_i,
    input wire phc_pkg::phc_en_t seq_enables_i,
    input wire logic button_event_i,
    input wire logic [7:0] reg_rdata_i,
    output phc_pkg::phc_en_t supply_en_o,
    output logic power_good_o,
    output logic spi_sel_o,
    output logic two_wire_mode_o,
    output logic [6:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    output logic reg_re_o
);
    import phc_pkg::*;

    if (CHARGE_CYC < 1 || CHARGE_CYC > 65535)
    begin : g_chk
        $error("CHARGE_CYC out of range");
    end

    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    phc_static_e st_reg;
    phc_sel_e sel_reg;
    logic irq_cap_reg;
    logic pg_reg;
    phc_en_t en_reg;
    logic irq_pu_n_reg;
    logic sel_pu_n_reg;
    logic [15:0] chg_cnt_reg;
    logic spi_sel_reg;
    logic tw_reg;
    logic [4:0] bit_cnt_reg;
    logic [7:0] cmd_reg;
    logic [7:0] data_reg;
    logic rd_tgl_reg;
    logic wr_tgl_reg;
    logic [7:0] out_shift_reg;
    logic sdo_reg;
    logic sdo_oe_n_reg;
    logic [2:0] rd_sync_reg;
    logic [2:0] wr_sync_reg;
    logic rd_load_reg;
    logic [7:0] rd_hold_reg;
    logic [6:0] addr_reg;
    logic [7:0] wdata_reg;
    logic we_reg;
    logic re_reg;
    logic spi_arst_n;
    logic [4:0] pins;

    assign pins = {lnk.irq_ready_pin, lnk.iface_select_pin,
                   lnk.host_ctrl_pin_three, lnk.host_ctrl_pin_two,
                   lnk.host_ctrl_pin_one};

    // Pins are asynchronous here; two flops each
    for (genvar i = 0; i < 5; i++)
    begin : g_sync
        always_ff @(posedge ref_clk_i or negedge reset_n_i)
        begin
            if (!reset_n_i)
            begin
                pin_meta_reg[i] <= 1'b0;
                pin_sync_reg[i] <= 1'b0;
            end
            else
            begin
                pin_meta_reg[i] <= pins[i];
                pin_sync_reg[i] <= pin_meta_reg[i];
            end
        end
    end

    // Static handover state machine
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_reg <= ST_SEQ;
            irq_cap_reg <= 1'b1;
        end
        else if (seq_start_i)
            st_reg <= ST_SEQ;
        else
        begin
            case (st_reg)
                ST_SEQ:
                    if (startup_done_i && static_mode_i)
                    begin
                        irq_cap_reg <= pin_sync_reg[4];
                        st_reg <= ST_WATCH;
                    end
                ST_WATCH:
                    if (pin_sync_reg[4] != irq_cap_reg)
                        st_reg <= ST_HOST;
                ST_HOST:
                    st_reg <= ST_HOST;
                default:
                    st_reg <= ST_SEQ;
            endcase
        end
    end

    // Power good follows the static capture by one cycle, or startup_done_i in dynamic mode
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pg_reg <= 1'b0;
        else if (seq_start_i)
            pg_reg <= 1'b0;
        else if (st_reg != ST_SEQ || (startup_done_i && !static_mode_i))
            pg_reg <= 1'b1;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            en_reg <= 4'h0;
            irq_pu_n_reg <= 1'b1;
        end
        else
        begin
            irq_pu_n_reg <= !(static_mode_i && st_reg != ST_HOST);
            if (st_reg == ST_HOST)
                en_reg <= pin_sync_reg[3:0];
            else if (static_mode_i)
                en_reg <= seq_enables_i & `PHC_EN_NO_LIN_B;
            else
                en_reg <= seq_enables_i;
        end
    end

    // Interface choice, once per start-up
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sel_reg <= SEL_IDLE;
            chg_cnt_reg <= 16'h0000;
            spi_sel_reg <= 1'b0;
            tw_reg <= 1'b0;
        end
        else if (seq_start_i)
        begin
            sel_reg <= SEL_IDLE;
            spi_sel_reg <= 1'b0;
            tw_reg <= 1'b0;
        end
        else
        begin
            case (sel_reg)
                SEL_IDLE:
                    if (!static_mode_i && button_event_i)
                    begin
                        sel_reg <= SEL_CHARGE;
                        chg_cnt_reg <= 16'h0000;
                    end
                SEL_CHARGE:
                    if (chg_cnt_reg == 16'(CHARGE_CYC - 1))
                        sel_reg <= SEL_SAMPLE;
                    else
                        chg_cnt_reg <= chg_cnt_reg + 16'h0001;
                SEL_SAMPLE:
                begin
                    spi_sel_reg <= pin_sync_reg[3];
                    tw_reg <= !pin_sync_reg[3];
                    sel_reg <= SEL_DONE;
                end
                SEL_DONE:
                    sel_reg <= SEL_DONE;
                default:
                    sel_reg <= SEL_IDLE;
            endcase
        end
    end

    // Pull-up only while charging; off again after the choice
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            sel_pu_n_reg <= 1'b1;
        else
            sel_pu_n_reg <= !(sel_reg == SEL_CHARGE ||
                              (sel_reg == SEL_IDLE && !static_mode_i &&
                               button_event_i));
    end

    // Serial side: deselect clears the bit counter
    assign spi_arst_n = reset_n_i & spi_sel_reg & !lnk.iface_select_pin;

    always_ff @(posedge lnk.host_ctrl_pin_one or negedge spi_arst_n)
    begin
        if (!spi_arst_n)
            bit_cnt_reg <= 5'd0;
        else if (bit_cnt_reg != 5'(`PHC_FRAME_BITS))
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
    end

    // Not cleared by deselect: the reference side still reads them
    always_ff @(posedge lnk.host_ctrl_pin_one or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cmd_reg <= 8'h00;
            data_reg <= 8'h00;
            rd_tgl_reg <= 1'b0;
            wr_tgl_reg <= 1'b0;
        end
        else if (spi_arst_n)
        begin
            if (bit_cnt_reg < 5'(`PHC_BYTE_BITS))
                cmd_reg <= {cmd_reg[6:0], lnk.host_ctrl_pin_three};
            else if (bit_cnt_reg < 5'(`PHC_FRAME_BITS) &&
                     !cmd_reg[`PHC_CMD_RD_BIT])
                data_reg <= {data_reg[6:0], lnk.host_ctrl_pin_three};
            if (bit_cnt_reg == 5'(`PHC_BYTE_BITS - 1) && cmd_reg[6])
                rd_tgl_reg <= !rd_tgl_reg;
            if (bit_cnt_reg == 5'(`PHC_FRAME_BITS - 1) &&
                !cmd_reg[`PHC_CMD_RD_BIT])
                wr_tgl_reg <= !wr_tgl_reg;
        end
    end

    // Output changes on the falling edge; deselect releases it at once
    always_ff @(negedge lnk.host_ctrl_pin_one or negedge spi_arst_n)
    begin
        if (!spi_arst_n)
        begin
            sdo_oe_n_reg <= 1'b1;
            sdo_reg <= 1'b0;
            out_shift_reg <= 8'h00;
        end
        else if (bit_cnt_reg == 5'(`PHC_BYTE_BITS) &&
                 cmd_reg[`PHC_CMD_RD_BIT])
        begin
            // Hold word is stable thanks to the byte gap
            sdo_reg <= rd_hold_reg[7];
            out_shift_reg <= {rd_hold_reg[6:0], 1'b0};
            sdo_oe_n_reg <= 1'b0;
        end
        else if (bit_cnt_reg == 5'(`PHC_FRAME_BITS))
            sdo_oe_n_reg <= 1'b1;
        else if (!sdo_oe_n_reg)
        begin
            sdo_reg <= out_shift_reg[7];
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end
    end

    // Toggle events cross into the reference domain
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rd_sync_reg <= 3'b000;
            wr_sync_reg <= 3'b000;
        end
        else
        begin
            rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
            wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            re_reg <= 1'b0;
            we_reg <= 1'b0;
            rd_load_reg <= 1'b0;
            addr_reg <= 7'h00;
            wdata_reg <= 8'h00;
            rd_hold_reg <= 8'h00;
        end
        else
        begin
            re_reg <= rd_sync_reg[2] ^ rd_sync_reg[1];
            we_reg <= wr_sync_reg[2] ^ wr_sync_reg[1];
            rd_load_reg <= re_reg;
            if (rd_sync_reg[2] ^ rd_sync_reg[1])
                addr_reg <= cmd_reg[6:0];
            else if (wr_sync_reg[2] ^ wr_sync_reg[1])
            begin
                addr_reg <= cmd_reg[6:0];
                wdata_reg <= data_reg;
            end
            if (rd_load_reg)
                rd_hold_reg <= reg_rdata_i;
        end
    end

    assign lnk.pin_two_dev = sdo_reg;
    assign lnk.pin_two_dev_oe_n = sdo_oe_n_reg;
    assign lnk.sel_pullup_en_n = sel_pu_n_reg;
    assign lnk.irq_pullup_en_n = irq_pu_n_reg;
    assign supply_en_o = en_reg;
    assign power_good_o = pg_reg;
    assign spi_sel_o = spi_sel_reg;
    assign two_wire_mode_o = tw_reg;
    assign reg_addr_o = addr_reg;
    assign reg_wdata_o = wdata_reg;
    assign reg_we_o = we_reg;
    assign reg_re_o = re_reg;
endmodule

/* phc_regs.svh */
// Purpose: constants shared by both ends of the supply control link
// Assumes: reference clock of 10 ns on both ends
// Notes: times in ns; charge and byte gap counts derived from them
`ifndef PHC_REGS_SVH
`define PHC_REGS_SVH
`define PHC_REF_PERIOD_NS 10
`define PHC_CHARGE_NS 1000
`define PHC_CHARGE_CYC \
    ((`PHC_CHARGE_NS + `PHC_REF_PERIOD_NS - 1) / `PHC_REF_PERIOD_NS)
`define PHC_SLOW_PERIOD_NS 71112
`define PHC_BYTE_GAP_NS (2 * `PHC_SLOW_PERIOD_NS)
`define PHC_BYTE_GAP_CYC \
    ((`PHC_BYTE_GAP_NS + `PHC_REF_PERIOD_NS - 1) / `PHC_REF_PERIOD_NS)
`define PHC_SCK_HALF_CYC 4
`define PHC_PIN_SETTLE_CYC 4
`define PHC_CMD_RD_BIT 7
`define PHC_BYTE_BITS 8
`define PHC_FRAME_BITS 16
`define PHC_EN_STEP_UP 0
`define PHC_EN_STEP_DOWN 1
`define PHC_EN_LIN_A 2
`define PHC_EN_LIN_B 3
`define PHC_EN_NO_LIN_B 4'h7
`endif

/* phc_pkg.sv */
// Purpose: types shared by both ends of the supply control link
// Assumes: nothing
// Notes: state codes are one-hot
package phc_pkg;
    typedef logic [3:0] phc_en_t;
    typedef enum logic [2:0] {
        ST_SEQ = 3'b001,
        ST_WATCH = 3'b010,
        ST_HOST = 3'b100
    } phc_static_e;
    typedef enum logic [3:0] {
        SEL_IDLE = 4'b0001,
        SEL_CHARGE = 4'b0010,
        SEL_SAMPLE = 4'b0100,
        SEL_DONE = 4'b1000
    } phc_sel_e;
    typedef enum logic [7:0] {
        H_IDLE = 8'b00000001,
        H_LEAD = 8'b00000010,
        H_LOW = 8'b00000100,
        H_HIGH = 8'b00001000,
        H_GAP = 8'b00010000,
        H_TRAIL = 8'b00100000,
        H_PIN = 8'b01000000,
        H_TAKE = 8'b10000000
    } phc_host_e;
endpackage

/* phc_link_if.sv */
// Purpose: pins between supply controller and host
// Assumes: pull-ups modelled as resolved levels
// Notes: no end drives high impedance; levels are resolved here
`timescale 1ns/1ps
interface phc_link_if;
    logic host_ctrl_pin_one;
    logic pin_two_dev;
    logic pin_two_dev_oe_n;
    logic pin_two_host;
    logic pin_two_host_oe_n;
    logic host_ctrl_pin_two;
    logic host_ctrl_pin_three;
    logic sel_host;
    logic sel_pullup_en_n;
    logic iface_select_pin;
    logic irq_host;
    logic irq_host_oe_n;
    logic irq_pullup_en_n;
    logic irq_ready_pin;

    // Undriven data line reads high, as with a pull-up
    assign host_ctrl_pin_two = !pin_two_dev_oe_n ? pin_two_dev :
                               !pin_two_host_oe_n ? pin_two_host : 1'b1;
    assign iface_select_pin = sel_host;
    assign irq_ready_pin = !irq_host_oe_n ? irq_host :
                           !irq_pullup_en_n ? 1'b1 : 1'b0;

    modport dev (
        input host_ctrl_pin_one,
        input host_ctrl_pin_two,
        input host_ctrl_pin_three,
        input iface_select_pin,
        input irq_ready_pin,
        output pin_two_dev,
        output pin_two_dev_oe_n,
        output sel_pullup_en_n,
        output irq_pullup_en_n
    );
    modport host (
        input host_ctrl_pin_two,
        output host_ctrl_pin_one,
        output pin_two_host,
        output pin_two_host_oe_n,
        output host_ctrl_pin_three,
        output sel_host,
        output irq_host,
        output irq_host_oe_n
    );
endinterface

/* phc_host.sv */
// Purpose: host end: drives supply pins or runs serial accesses
// Assumes: static_mode_i matches the device configuration
// Notes: serial clock made by dividing ref_clk_i
`timescale 1ns/1ps
`include "phc_regs.svh"
module phc_host #(
    parameter int SCK_HALF_CYC = `PHC_SCK_HALF_CYC,
    parameter int BYTE_GAP_CYC = `PHC_BYTE_GAP_CYC,
    parameter int PIN_SETTLE_CYC = `PHC_PIN_SETTLE_CYC
) (
    phc_link_if.host lnk,
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic static_mode_i,
    input wire logic ctrl_req_i,
    input wire phc_pkg::phc_en_t ctrl_en_i,
    input wire logic xfer_req_i,
    input wire logic xfer_rd_i,
    input wire logic [6:0] xfer_addr_i,
    input wire logic [7:0] xfer_wdata_i,
    output logic ctrl_taken_o,
    output logic xfer_busy_o,
    output logic xfer_done_o,
    output logic [7:0] xfer_rdata_o
);
    import phc_pkg::*;

    // Sampling needs the two-flop delay inside a half period
    if (SCK_HALF_CYC < 3 || SCK_HALF_CYC > 65535 || BYTE_GAP_CYC < 1 ||
        BYTE_GAP_CYC > 65535 || PIN_SETTLE_CYC < 1 ||
        PIN_SETTLE_CYC > 65535)
    begin : g_chk
        $error("host timing parameter out of range");
    end

    phc_host_e st_reg;
    logic [15:0] cnt_reg;
    logic [4:0] bit_reg;
    logic [15:0] tx_reg;
    logic [7:0] rx_reg;
    logic [7:0] rdata_reg;
    logic sck_reg;
    logic cs_n_reg;
    logic sdi_reg;
    phc_en_t en_reg;
    logic irq_oe_n_reg;
    logic taken_reg;
    logic done_reg;
    logic [1:0] sdo_sync_reg;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            sdo_sync_reg <= 2'b00;
        else
            sdo_sync_reg <= {sdo_sync_reg[0], lnk.host_ctrl_pin_two};
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_reg <= H_IDLE;
            cnt_reg <= 16'h0000;
            bit_reg <= 5'd0;
            tx_reg <= 16'h0000;
            rx_reg <= 8'h00;
            rdata_reg <= 8'h00;
            sck_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            sdi_reg <= 1'b0;
            en_reg <= 4'h0;
            irq_oe_n_reg <= 1'b1;
            taken_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            taken_reg <= 1'b0;
            done_reg <= 1'b0;
            cnt_reg <= cnt_reg + 16'h0001;
            case (st_reg)
                H_IDLE:
                begin
                    cnt_reg <= 16'h0000;
                    if (static_mode_i && ctrl_req_i)
                    begin
                        en_reg <= ctrl_en_i;
                        st_reg <= H_PIN;
                    end
                    else if (!static_mode_i && xfer_req_i)
                    begin
                        tx_reg <= {xfer_rd_i, xfer_addr_i, xfer_wdata_i};
                        cs_n_reg <= 1'b0;
                        bit_reg <= 5'd0;
                        st_reg <= H_LEAD;
                    end
                end
                H_PIN:
                    if (cnt_reg == 16'(PIN_SETTLE_CYC - 1))
                        st_reg <= H_TAKE;
                H_TAKE:
                begin
                    irq_oe_n_reg <= 1'b0;
                    taken_reg <= 1'b1;
                    st_reg <= H_IDLE;
                end
                H_LEAD, H_GAP:
                    if (cnt_reg == 16'((st_reg == H_GAP) ?
                        BYTE_GAP_CYC - 1 : SCK_HALF_CYC - 1))
                    begin
                        sck_reg <= 1'b0;
                        sdi_reg <= tx_reg[15];
                        tx_reg <= {tx_reg[14:0], 1'b0};
                        cnt_reg <= 16'h0000;
                        st_reg <= H_LOW;
                    end
                H_LOW:
                    if (cnt_reg == 16'(SCK_HALF_CYC - 1))
                    begin
                        sck_reg <= 1'b1;
                        rx_reg <= {rx_reg[6:0], sdo_sync_reg[1]};
                        bit_reg <= bit_reg + 5'd1;
                        cnt_reg <= 16'h0000;
                        st_reg <= H_HIGH;
                    end
                H_HIGH:
                    if (cnt_reg == 16'(SCK_HALF_CYC - 1))
                    begin
                        cnt_reg <= 16'h0000;
                        if (bit_reg == 5'(`PHC_FRAME_BITS))
                            st_reg <= H_TRAIL;
                        else if (bit_reg == 5'(`PHC_BYTE_BITS))
                            st_reg <= H_GAP;
                        else
                        begin
                            sck_reg <= 1'b0;
                            sdi_reg <= tx_reg[15];
                            tx_reg <= {tx_reg[14:0], 1'b0};
                            st_reg <= H_LOW;
                        end
                    end
                H_TRAIL:
                begin
                    cs_n_reg <= 1'b1;
                    rdata_reg <= rx_reg;
                    done_reg <= 1'b1;
                    st_reg <= H_IDLE;
                end
                default:
                    st_reg <= H_IDLE;
            endcase
        end
    end

    // Static pins always valid; serial pin two never driven by host
    assign lnk.host_ctrl_pin_one = static_mode_i ?
        en_reg[`PHC_EN_STEP_UP] : sck_reg;
    assign lnk.pin_two_host = en_reg[`PHC_EN_STEP_DOWN];
    assign lnk.pin_two_host_oe_n = !static_mode_i;
    assign lnk.host_ctrl_pin_three = static_mode_i ?
        en_reg[`PHC_EN_LIN_A] : sdi_reg;
    assign lnk.sel_host = static_mode_i ?
        en_reg[`PHC_EN_LIN_B] : cs_n_reg;
    assign lnk.irq_host = 1'b0;
    assign lnk.irq_host_oe_n = irq_oe_n_reg;
    assign ctrl_taken_o = taken_reg;
    assign xfer_busy_o = (st_reg != H_IDLE);
    assign xfer_done_o = done_reg;
    assign xfer_rdata_o = rdata_reg;
endmodule

/* phc_properties.sv */
// Purpose: wire-level checks between the host end and the device end
// Assumes: select pull-up charge count of 4 in the bench
// Notes: sees only the link wires, one clock domain
`timescale 1ns/1ps
module phc_link_checker (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic host_ctrl_pin_one,
    input wire logic host_ctrl_pin_three,
    input wire logic pin_two_dev,
    input wire logic pin_two_dev_oe_n,
    input wire logic pin_two_host_oe_n,
    input wire logic sel_host,
    input wire logic sel_pullup_en_n,
    input wire logic irq_host_oe_n,
    input wire logic irq_pullup_en_n,
    input wire logic irq_ready_pin
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Pin needs the full charge time before it is sampled
    sequence charge_s;
        !sel_pullup_en_n [*4];
    endsequence
    chk_sel_charge: assert property ($fell(sel_pullup_en_n) |->
        charge_s ##[1:4] sel_pullup_en_n) else $error("select pull-up time");
    chk_sdo_deselect: assert property ($rose(sel_host) |->
        ##[0:2] pin_two_dev_oe_n) else $error("data out kept on deselect");
    chk_sdo_drive_fall: assert property ($fell(pin_two_dev_oe_n) |->
        !host_ctrl_pin_one) else $error("data out enabled off falling edge");
    chk_sdo_release: assert property ($rose(pin_two_dev_oe_n) |->
        !host_ctrl_pin_one || sel_host) else $error("data out released late");
    chk_sdo_hold_high: assert property (!sel_host && $past(!sel_host) &&
        host_ctrl_pin_one && $past(host_ctrl_pin_one) |-> $stable(pin_two_dev))
        else $error("data out moved while clock high");
    chk_irq_pullup_cause: assert property ($rose(irq_pullup_en_n) |->
        !$past(irq_ready_pin)) else $error("ready pull-up dropped unprompted");
    chk_sck_idle_high: assert property (pin_two_host_oe_n && sel_host &&
        $past(sel_host) |-> host_ctrl_pin_one) else $error("serial clock idle low");
    chk_pins_before_ready: assert property ($fell(irq_host_oe_n) |->
        $stable(host_ctrl_pin_one) && $stable(host_ctrl_pin_three) &&
        $stable(sel_host)) else $error("pins moved as ready was pulled");
endmodule

/* pmu_host_control_interface_tb_top.sv */
// Purpose: runs both link ends against each other
// Assumes: bench acts as the register bank behind the device
// Notes: short charge and byte gap counts keep the run brief
`timescale 1ns/1ps
`define CHK(a, b) \
    tests_run++; \
    if ((a) !== (b)) \
    begin \
        fails++; \
        $display("Error t=%0t got %0h exp %0h", $time, a, b); \
    end
module pmu_host_control_interface_tb_top;
    import phc_pkg::*;
    logic clk, reset_n, dev_static, host_static, seq_start, startup_done;
    logic button, ctrl_req, xfer_req, xfer_rd, power_good, spi_sel, two_wire;
    logic reg_we, reg_re, ctrl_taken, busy, done;
    phc_en_t seq_en, ctrl_en, supply_en;
    logic [6:0] xfer_addr, reg_addr;
    logic [7:0] xfer_wdata, reg_wdata, rdata, xfer_rdata;
    logic [7:0] mem [128];
    int fails, tests_run;
    // Rows: read flag, address, data written or expected back
    logic [15:0] rows [5] = '{16'h7FA5, 16'h003C, 16'hFFA5, 16'h803C,
        16'hFFA5};
    phc_link_if lnk ();
    phc_device #(.CHARGE_CYC(4)) phc_device_i (.lnk(lnk.dev),
        .ref_clk_i(clk), .reset_n_i(reset_n), .static_mode_i(dev_static),
        .seq_start_i(seq_start), .startup_done_i(startup_done),
        .seq_enables_i(seq_en), .button_event_i(button), .reg_rdata_i(rdata),
        .supply_en_o(supply_en), .power_good_o(power_good),
        .spi_sel_o(spi_sel), .two_wire_mode_o(two_wire),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_we_o(reg_we),
        .reg_re_o(reg_re));
    phc_host #(.BYTE_GAP_CYC(20)) phc_host_i (.lnk(lnk.host),
        .ref_clk_i(clk), .reset_n_i(reset_n), .static_mode_i(host_static),
        .ctrl_req_i(ctrl_req), .ctrl_en_i(ctrl_en), .xfer_req_i(xfer_req),
        .xfer_rd_i(xfer_rd), .xfer_addr_i(xfer_addr),
        .xfer_wdata_i(xfer_wdata), .ctrl_taken_o(ctrl_taken),
        .xfer_busy_o(busy), .xfer_done_o(done), .xfer_rdata_o(xfer_rdata));
    phc_link_checker phc_link_checker_i (.ref_clk_i(clk),
        .reset_n_i(reset_n), .host_ctrl_pin_one(lnk.host_ctrl_pin_one),
        .host_ctrl_pin_three(lnk.host_ctrl_pin_three),
        .pin_two_dev(lnk.pin_two_dev), .pin_two_dev_oe_n(lnk.pin_two_dev_oe_n),
        .pin_two_host_oe_n(lnk.pin_two_host_oe_n), .sel_host(lnk.sel_host),
        .sel_pullup_en_n(lnk.sel_pullup_en_n),
        .irq_host_oe_n(lnk.irq_host_oe_n),
        .irq_pullup_en_n(lnk.irq_pullup_en_n),
        .irq_ready_pin(lnk.irq_ready_pin));
    assign rdata = mem[reg_addr];
    always @(posedge clk)
        if (reg_we === 1'b1)
            mem[reg_addr] <= reg_wdata;
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task restart(input logic ds, input logic hs);
        reset_n = 0;
        dev_static = ds;
        host_static = hs;
        tick(20);
        reset_n = 1;
        tick(2);
    endtask
    task start_seq();
        seq_start = 1;
        tick(1);
        seq_start = 0;
        tick(1);
    endtask
    // Long settle covers charge, sample and release
    task press();
        button = 1;
        tick(1);
        button = 0;
        tick(30);
    endtask
    task ctrl(input phc_en_t e);
        ctrl_en = e;
        ctrl_req = 1;
        tick(1);
        ctrl_req = 0;
        repeat (40)
        begin
            tick(1);
            if (ctrl_taken === 1'b1)
                break;
        end
        tick(12);
    endtask
    // Reads send inverted data on the input line; it must be ignored
    task xfer(input logic [15:0] r);
        xfer_rd = r[15];
        xfer_addr = r[14:8];
        xfer_wdata = r[15] ? ~r[7:0] : r[7:0];
        xfer_req = 1;
        tick(1);
        xfer_req = 0;
        repeat (400)
        begin
            tick(1);
            if (done === 1'b1)
                break;
        end
        tick(4);
        if (r[15])
        begin
            `CHK(xfer_rdata, r[7:0])
            `CHK(reg_addr, r[14:8])
            `CHK(lnk.pin_two_dev_oe_n, 1'b1)
        end
        else
        begin
            `CHK({reg_addr, reg_wdata}, r[14:0])
        end
    endtask
    task test_done();
        $display("Checks %0d Errors %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        {seq_start, startup_done, button, ctrl_req, xfer_req, xfer_rd} = 0;
        {ctrl_en, xfer_addr, xfer_wdata, fails, tests_run} = 0;
        seq_en = 4'hF;
        restart(0, 0);
        start_seq();
        `CHK(lnk.sel_pullup_en_n, 1'b1)
        press();
        `CHK({spi_sel, two_wire}, 2'b10)
        `CHK(lnk.sel_pullup_en_n, 1'b1)
        foreach (rows[i])
            xfer(rows[i]);
        restart(1, 1);
        start_seq();
        `CHK(lnk.irq_ready_pin, 1'b1)
        `CHK(supply_en, 4'h7)
        `CHK(power_good, 1'b0)
        startup_done = 1;
        tick(1);
        startup_done = 0;
        tick(2);
        `CHK(power_good, 1'b1)
        `CHK(supply_en, 4'h7)
        ctrl(4'hA);
        `CHK(supply_en, 4'hA)
        `CHK(lnk.irq_pullup_en_n, 1'b1)
        ctrl(4'h5);
        `CHK(supply_en, 4'h5)
        restart(0, 1);
        ctrl(4'h0);
        start_seq();
        press();
        `CHK({spi_sel, two_wire}, 2'b01)
        ctrl(4'h8);
        press();
        `CHK({spi_sel, two_wire}, 2'b01)
        start_seq();
        press();
        `CHK({spi_sel, two_wire}, 2'b10)
        test_done();
    end
    initial
    begin
        #300000;
        fails++;
        test_done();
    end
endmodule
